// File: include/rdo_regs.svh
// Timing constants for the RDS bit output block
`ifndef RDO_REGS_SVH
`define RDO_REGS_SVH

// ****************************************
// Reference and bit rate
// ****************************************
// Crystal reference in Hz
`define RDO_XTAL_HZ 64'd4332000
// Bit rate in milli-hertz (1187.5 Hz)
`define RDO_BIT_RATE_MHZ 64'd1187500
// Crystal cycles per bit clock period (3648)
`define RDO_BIT_CYCLES (`RDO_XTAL_HZ * 64'd1000 / `RDO_BIT_RATE_MHZ)

// ****************************************
// Lock and validity times
// ****************************************
// Typical and longest lock time in ms
`define RDO_LOCK_TYP_MS 64'd100
`define RDO_LOCK_MAX_MS 64'd200
// Crystal cycles for the longest lock time, rounded up
`define RDO_LOCK_CYCLES ((`RDO_XTAL_HZ * `RDO_LOCK_MAX_MS + 64'd999) / 64'd1000)
// Data valid window after the reference edge, in ns (416.7 us)
`define RDO_VALID_NS 64'd416700
// System clock in Hz
`define RDO_CLK_HZ 64'd40000000

`endif

// File: include/rdo_pkg.sv
// Types for the RDS bit output block
package rdo_pkg;

   // Edge on which serial data is replaced
   typedef enum logic [0:0] {
      RDO_EDGE_RISE = 1'b0,
      RDO_EDGE_FALL = 1'b1
   } rdo_edge_t;

   // One demodulated bit with its quality tag
   typedef struct packed {
      logic data;
      logic good;
   } rdo_bit_t;

   // Lock tracking state
   typedef enum logic [0:0] {
      RDO_ACQUIRE = 1'b0,
      RDO_LOCKED = 1'b1
   } rdo_lock_t;

endpackage : rdo_pkg

// File: include/rdo_xfer_if.sv
// Signals crossing from the system clock side to the crystal side
`timescale 1ns/1ps
`default_nettype none

interface rdo_xfer_if;
   logic bit_tog;
   rdo_pkg::rdo_bit_t bit_word;
   logic traffic;
   logic signal;
   rdo_pkg::rdo_edge_t phase;
   logic acq_tog;
   logic link_rst;

   modport src (
      output bit_tog,
      output bit_word,
      output traffic,
      output signal,
      output phase,
      output acq_tog,
      output link_rst
   );
   modport dst (
      input bit_tog,
      input bit_word,
      input traffic,
      input signal,
      input phase,
      input acq_tog,
      input link_rst
   );
endinterface : rdo_xfer_if

`default_nettype wire

// File: hw/rdo_bit_capture.sv
// System clock side: holds demodulated bits and status for the crystal side
`timescale 1ns/1ps
`default_nettype none

module rdo_bit_capture (
   input wire logic clk,
   input wire logic rst,
   input wire logic demod_valid,
   input wire logic demod_bit,
   input wire logic demod_good,
   input wire logic traffic_present,
   input wire logic signal_present,
   input wire logic pll_phase,
   input wire logic acquire,
   rdo_xfer_if.src xf
);

   logic bit_tog;
   logic next_bit_tog;
   rdo_pkg::rdo_bit_t bit_word;
   rdo_pkg::rdo_bit_t next_bit_word;
   logic acq_tog;
   logic next_acq_tog;
   logic traffic;
   logic signal;
   rdo_pkg::rdo_edge_t phase;
   logic link_rst;

   // Next values: word held stable, toggle flips once per new bit
   always_comb begin
      next_bit_tog = bit_tog;
      next_bit_word = bit_word;
      next_acq_tog = acq_tog;
      if (demod_valid) begin
         next_bit_tog = ~bit_tog;
         next_bit_word.data = demod_bit;
         next_bit_word.good = demod_good;
      end
      if (acquire) begin
         next_acq_tog = ~acq_tog;
      end
   end

   // Registers; every crossing source comes from a flop
   always_ff @(posedge clk) begin
      link_rst <= rst;
      if (rst) begin
         bit_tog <= 1'b0;
         bit_word <= '0;
         acq_tog <= 1'b0;
         traffic <= 1'b0;
         signal <= 1'b0;
         phase <= rdo_pkg::RDO_EDGE_RISE;
      end else begin
         bit_tog <= next_bit_tog;
         bit_word <= next_bit_word;
         acq_tog <= next_acq_tog;
         // Pre-combined so the flag crosses as one bit, with no false high on skew
         traffic <= traffic_present & signal_present;
         signal <= signal_present;
         phase <= rdo_pkg::rdo_edge_t'(pll_phase);
      end
   end

   assign xf.bit_tog = bit_tog;
   assign xf.bit_word = bit_word;
   assign xf.acq_tog = acq_tog;
   assign xf.traffic = traffic;
   assign xf.signal = signal;
   assign xf.phase = phase;
   assign xf.link_rst = link_rst;

endmodule : rdo_bit_capture

`default_nettype wire

// File: hw/rdo_bit_output.sv
// RDS bit stream output: bit clock, serial data, quality and traffic flags
// Behaviour
// - Bit clock runs at 1187.5 Hz, one data bit per period.
// - Data changes on rising or falling edge, chosen by PLL phase state.
// - Quality flag high for good data, low for poor or bad data.
// - Traffic flag high for TRAFFIC_CARRIER_FLAG plus RDS, low for RDS alone.
// - Logic held in reset while reset input high, runs when low.
// - Stream untrusted until lock time, at most 200 ms, has passed.
// - All link timing, bit clock included, derived from 4.332 MHz crystal.
`include "rdo_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rdo_bit_output #(
   parameter int unsigned BIT_CYCLES = 32'(`RDO_BIT_CYCLES),
   parameter int unsigned LOCK_CYCLES = 32'(`RDO_LOCK_CYCLES)
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic crystal_in,
   input wire logic demod_valid,
   input wire logic demod_bit,
   input wire logic demod_good,
   input wire logic traffic_present,
   input wire logic signal_present,
   input wire logic pll_phase,
   input wire logic acquire,
   output logic bit_clock,
   output logic serial_data,
   output logic quality_flag,
   output logic traffic_carrier_flag,
   output logic stream_locked
);

   localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;
   localparam int unsigned CW = $clog2(BIT_CYCLES);
   localparam int unsigned LW = $clog2(LOCK_CYCLES + 1);

   // ****************************************
   // System clock side
   // ****************************************
   rdo_xfer_if xf ();

   rdo_bit_capture u_capture (
      .clk(clk),
      .rst(rst),
      .demod_valid(demod_valid),
      .demod_bit(demod_bit),
      .demod_good(demod_good),
      .traffic_present(traffic_present),
      .signal_present(signal_present),
      .pll_phase(pll_phase),
      .acquire(acquire),
      .xf(xf)
   );

   // ****************************************
   // Crystal side synchronisers
   // ****************************************
   logic rst_s1;
   logic rst_s2;
   logic tog_s1;
   logic tog_s2;
   logic acq_s1;
   logic acq_s2;
   logic trf_s1;
   logic trf_s2;
   logic sig_s1;
   logic sig_s2;
   logic phase_s1;
   logic phase_s2;

   // reset, bit toggle, acquire toggle, flag and phase crossing
   // Two flops per level; first stages feed nothing else
   always_ff @(posedge crystal_in) begin
      rst_s1 <= xf.link_rst;
      rst_s2 <= rst_s1;
      tog_s1 <= xf.bit_tog;
      tog_s2 <= tog_s1;
      acq_s1 <= xf.acq_tog;
      acq_s2 <= acq_s1;
      trf_s1 <= xf.traffic;
      trf_s2 <= trf_s1;
      sig_s1 <= xf.signal;
      sig_s2 <= sig_s1;
      phase_s1 <= xf.phase;
      phase_s2 <= phase_s1;
   end

   // ****************************************
   // Crystal side state
   // ****************************************
   logic [CW-1:0] bit_cnt;
   logic [CW-1:0] next_bit_cnt;
   logic tog_seen;
   logic next_tog_seen;
   logic acq_seen;
   logic next_acq_seen;
   rdo_pkg::rdo_bit_t pend;
   rdo_pkg::rdo_bit_t next_pend;
   logic pend_fresh;
   logic next_pend_fresh;
   rdo_pkg::rdo_edge_t edge_sel;
   rdo_pkg::rdo_edge_t next_edge_sel;
   logic [LW-1:0] lock_cnt;
   logic [LW-1:0] next_lock_cnt;
   rdo_pkg::rdo_lock_t lock_state;
   rdo_pkg::rdo_lock_t next_lock_state;
   logic next_bit_clock;
   logic next_serial_data;
   logic next_quality_flag;
   logic next_traffic_flag;

   logic new_bit;
   logic at_wrap;
   logic at_half;
   logic update;
   rdo_pkg::rdo_bit_t src_word;

   // Next values for the link
   always_comb begin
      new_bit = (tog_s2 != tog_seen);
      at_wrap = (bit_cnt == CW'(BIT_CYCLES - 1));
      at_half = (bit_cnt == CW'(HALF_CYCLES - 1));

      next_bit_cnt = at_wrap ? '0 : bit_cnt + CW'(1);
      next_bit_clock = at_wrap ? 1'b1 : (at_half ? 1'b0 : bit_clock);

      next_edge_sel = at_wrap ? rdo_pkg::rdo_edge_t'(phase_s2) : edge_sel;
      update = (edge_sel == rdo_pkg::RDO_EDGE_RISE) ? at_wrap : at_half;

      // Word stable in source once its toggle has crossed
      next_tog_seen = tog_s2;
      src_word = new_bit ? xf.bit_word : pend;
      next_pend = src_word;
      // A bit arriving on an update is shown at once, so it is consumed there
      next_pend_fresh = update ? 1'b0 : (new_bit ? 1'b1 : pend_fresh);

      next_serial_data = serial_data;
      next_quality_flag = quality_flag;
      if (update) begin
         next_serial_data = src_word.data;
         // quality per bit
         // A repeated stale bit is reported poor
         next_quality_flag = src_word.good & (new_bit | pend_fresh);
      end

      next_traffic_flag = sig_s2 & trf_s2;

      next_acq_seen = acq_s2;
      next_lock_cnt = lock_cnt;
      next_lock_state = lock_state;
      if (acq_s2 != acq_seen) begin
         next_lock_cnt = '0;
         next_lock_state = rdo_pkg::RDO_ACQUIRE;
      end else begin
         unique case (lock_state)
            rdo_pkg::RDO_ACQUIRE: begin
               if (lock_cnt == LW'(LOCK_CYCLES - 1)) begin
                  next_lock_state = rdo_pkg::RDO_LOCKED;
               end
               next_lock_cnt = lock_cnt + LW'(1);
            end
            rdo_pkg::RDO_LOCKED: begin
               next_lock_cnt = lock_cnt;
            end
         endcase
      end
   end

   // Registers for the link
   always_ff @(posedge crystal_in) begin
      if (rst_s2) begin
         bit_cnt <= '0;
         bit_clock <= 1'b0;
         tog_seen <= 1'b0;
         acq_seen <= 1'b0;
         pend <= '0;
         pend_fresh <= 1'b0;
         edge_sel <= rdo_pkg::RDO_EDGE_RISE;
         serial_data <= 1'b0;
         quality_flag <= 1'b0;
         traffic_carrier_flag <= 1'b0;
         lock_cnt <= '0;
         lock_state <= rdo_pkg::RDO_ACQUIRE;
         stream_locked <= 1'b0;
      end else begin
         bit_cnt <= next_bit_cnt;
         bit_clock <= next_bit_clock;
         tog_seen <= next_tog_seen;
         acq_seen <= next_acq_seen;
         pend <= next_pend;
         pend_fresh <= next_pend_fresh;
         edge_sel <= next_edge_sel;
         serial_data <= next_serial_data;
         quality_flag <= next_quality_flag;
         traffic_carrier_flag <= next_traffic_flag;
         lock_cnt <= next_lock_cnt;
         lock_state <= next_lock_state;
         stream_locked <= (next_lock_state == rdo_pkg::RDO_LOCKED);
      end
   end

endmodule : rdo_bit_output

`default_nettype wire

// File: bench/rdo_bit_output_props.sv
// Checker for the RDS bit output block
`timescale 1ns/1ps
`default_nettype none
module rdo_bit_output_props #(
   parameter int unsigned BIT_CYCLES = 32,
   parameter int unsigned LOCK_CYCLES = 50
) (
   input wire logic rst,
   input wire logic crystal_in,
   input wire logic traffic_present,
   input wire logic signal_present,
   input wire logic bit_clock,
   input wire logic serial_data,
   input wire logic quality_flag,
   input wire logic traffic_carrier_flag,
   input wire logic stream_locked
);
   int unsigned run;
   int unsigned low_run;
   default clocking cb @(posedge crystal_in); endclocking
   default disable iff (rst);
   // Crystal cycles since the last bit clock edge
   always_ff @(posedge crystal_in) begin
      if (rst || $changed(bit_clock)) begin
         run <= 0;
      end else begin
         run <= run + 1;
      end
   end
   // Crystal cycles with the lock flag low
   always_ff @(posedge crystal_in) begin
      if (rst || stream_locked) begin
         low_run <= 0;
      end else begin
         low_run <= low_run + 1;
      end
   end
   // Edge spacing, data timing, flags and lock
   chk_high_half: assert property (
      $fell(bit_clock) |-> run == BIT_CYCLES / 2 - 1) else $error("high time wrong");
   chk_low_half: assert property (
      $rose(bit_clock) && run < BIT_CYCLES |-> run == BIT_CYCLES / 2 - 1)
      else $error("low time wrong");
   chk_data_edge: assert property (
      $changed(serial_data) |-> $changed(bit_clock)) else $error("data off edge");
   chk_quality_flag_edge: assert property (
      $changed(quality_flag) |-> $changed(bit_clock)) else $error("quality off edge");
   chk_flag_off: assert property (
      !signal_present [*8] |-> !traffic_carrier_flag) else $error("flag without signal");
   chk_flag_on: assert property (
      (signal_present && traffic_present) [*8] |-> traffic_carrier_flag)
      else $error("flag missing");
   chk_lock_wait: assert property (
      $rose(stream_locked) |-> low_run >= LOCK_CYCLES) else $error("early lock");
   chk_reset_clear: assert property (
      $fell(rst) |-> !bit_clock && !serial_data && !quality_flag && !stream_locked
      && !traffic_carrier_flag) else $error("outputs set in reset");
   cover property ($rose(stream_locked));
   cover property ($changed(serial_data) && $fell(bit_clock));
   cover property ($rose(traffic_carrier_flag));
endmodule : rdo_bit_output_props
bind rdo_bit_output rdo_bit_output_props #(.BIT_CYCLES(BIT_CYCLES), .LOCK_CYCLES(LOCK_CYCLES))
   rdo_bit_output_props_i (.rst(rst), .crystal_in(crystal_in),
   .traffic_present(traffic_present), .signal_present(signal_present),
   .bit_clock(bit_clock), .serial_data(serial_data), .quality_flag(quality_flag),
   .traffic_carrier_flag(traffic_carrier_flag), .stream_locked(stream_locked));
`default_nettype wire

// File: bench/rdo_rx_model.sv
// Receiver model that samples the recovered bit stream
`timescale 1ns/1ps
`default_nettype none
module rdo_rx_model (
   input wire logic crystal_in,
   input wire logic rst,
   input wire logic bit_clock,
   input wire logic serial_data,
   input wire logic quality_flag,
   input wire logic stream_locked,
   output logic [7:0] n_cap,
   output logic cap_data,
   output logic cap_good,
   output logic chg_level
);
   logic bclk_q;
   logic sd_q;
   // bit and quality taken after rising edge
   always @(posedge crystal_in) begin
      bclk_q <= bit_clock;
      sd_q <= serial_data;
      if (sd_q !== serial_data) chg_level <= bit_clock;
      if (rst) begin
         n_cap <= 8'h00;
      end else if (bit_clock && !bclk_q && stream_locked) begin
         n_cap <= n_cap + 8'h01;
         cap_data <= serial_data;
         cap_good <= quality_flag;
      end
   end
endmodule : rdo_rx_model
`default_nettype wire

// File: bench/tb_rdo_bit_output.sv
// Testbench for the RDS bit output block
`timescale 1ns/1ps
`default_nettype none
module tb_rdo_bit_output;
   logic clk = 1'b0;
   logic crystal_in = 1'b0;
   logic rst = 1'b1;
   logic demod_valid = 1'b0;
   logic demod_bit = 1'b0;
   logic demod_good = 1'b0;
   logic traffic_present = 1'b0;
   logic signal_present = 1'b0;
   logic pll_phase = 1'b0;
   logic acquire = 1'b0;
   logic bit_clock, serial_data, quality_flag, traffic_carrier_flag, stream_locked;
   logic cap_data, cap_good, chg_level;
   logic [7:0] n_cap;
   int error_cnt = 0;
   int n_checks = 0;
   // System and crystal clocks
   always #12.5 clk = ~clk;
   always #6 crystal_in = ~crystal_in;
   rdo_bit_output #(.BIT_CYCLES(32), .LOCK_CYCLES(50)) rdo_bit_output_i (
      .clk(clk), .rst(rst), .crystal_in(crystal_in), .demod_valid(demod_valid),
      .demod_bit(demod_bit), .demod_good(demod_good), .traffic_present(traffic_present),
      .signal_present(signal_present), .pll_phase(pll_phase), .acquire(acquire),
      .bit_clock(bit_clock), .serial_data(serial_data), .quality_flag(quality_flag),
      .traffic_carrier_flag(traffic_carrier_flag), .stream_locked(stream_locked));
   rdo_rx_model rdo_rx_model_i (
      .crystal_in(crystal_in), .rst(rst), .bit_clock(bit_clock), .serial_data(serial_data),
      .quality_flag(quality_flag), .stream_locked(stream_locked), .n_cap(n_cap),
      .cap_data(cap_data), .cap_good(cap_good), .chg_level(chg_level));
   task automatic cmp(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask : cmp
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude
   // Waits for one receiver capture
   task automatic wait_cap;
      logic [7:0] old;
      old = n_cap;
      for (int i = 0; i < 200; i++) begin
         @(posedge clk);
         if (n_cap !== old) return;
      end
      cmp("capture", 1'b1, 1'b0);
      conclude();
   endtask : wait_cap
   task automatic wait_lock;
      for (int i = 0; i < 200; i++) begin
         @(posedge clk);
         if (stream_locked === 1'b1) return;
      end
      cmp("lock", 1'b1, stream_locked);
      conclude();
   endtask : wait_lock
   task automatic send(input logic d, input logic g);
      demod_bit <= d;
      demod_good <= g;
      demod_valid <= 1'b1;
      @(posedge clk);
      demod_valid <= 1'b0;
   endtask : send
   // bits on the chosen edge, then a stale repeat
   task automatic t_stream(input logic p);
      logic [3:0] pat;
      pat = 4'b1010;
      pll_phase <= p;
      wait_cap();
      wait_cap();
      for (int i = 0; i < 4; i++) begin
         send(pat[i], i[0]);
         wait_cap();
         cmp("data", pat[i], cap_data);
         cmp("quality", i[0], cap_good);
         if (i > 0) cmp("edge", !p, chg_level);
         wait_cap();
         cmp("repeat", pat[i], cap_data);
         cmp("stale", 1'b0, cap_good);
      end
   endtask : t_stream
   // flag over all carrier and signal levels
   task automatic t_traffic;
      for (int i = 0; i < 4; i++) begin
         traffic_present <= i[0];
         signal_present <= i[1];
         repeat (10) @(posedge clk);
         cmp("traffic", i[0] & i[1], traffic_carrier_flag);
      end
      traffic_present <= 1'b0;
      signal_present <= 1'b0;
   endtask : t_traffic
   task automatic t_acquire;
      acquire <= 1'b1;
      @(posedge clk);
      acquire <= 1'b0;
      repeat (20) @(posedge clk);
      cmp("relock early", 1'b0, stream_locked);
      wait_lock();
   endtask : t_acquire
   // reset in mid-run clears bit clock, data, quality and lock outputs
   task automatic t_reset;
      rst <= 1'b1;
      repeat (60) @(posedge clk);
      cmp("clock in reset", 1'b0, bit_clock);
      cmp("data in reset", 1'b0, serial_data);
      cmp("quality in reset", 1'b0, quality_flag);
      cmp("lock in reset", 1'b0, stream_locked);
      rst <= 1'b0;
      wait_lock();
   endtask : t_reset
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      wait_lock();
      t_stream(1'b0);
      t_stream(1'b1);
      t_traffic();
      t_acquire();
      t_reset();
      conclude();
   end
endmodule : tb_rdo_bit_output
`default_nettype wire
